// ### prs_scan.sv
`timescale 1ns/10ps
// Operation
// - split screen is forced off while rotation is enabled
// - alternate scheme: memory and input clock run at twice pixel rate
// - default scheme: pixel rate equals input clock rate
// - default scheme: vertical pan moves in two-line steps
// - alternate scheme: vertical pan moves in single-line steps
// - rotation bit 2 set makes memory clock equal input clock
// - enabling rotation leaves frame-buffer contents untouched
// - writing 80h enables default rotated scheme
// - writing C0h enables alternate rotated scheme
// - alternate scheme with zero selects: pixel clock is input over two
// - pixel clock selects divide the pixel clock further
// - byte offset zero maps to upper left of rotated display
// - alternate scheme: fetches within a line step by rotated width bytes; line starts step back one byte
// - rotation off: landscape refresh, other rotation fields ignored
// - scheme select zero is default, one is alternate
// - rotation on: start address is a byte offset, not word
// - rotation on: memory clock switching speeds memory clock during host access
module prs_scan #(
  parameter int ADDR_W = prs_pkg::PRS_ADDR_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic host_access,
  input wire logic [9:0] horiz_active_len,
  input wire logic [9:0] vert_active_len,
  output logic pixel_tick,
  output logic mem_tick,
  output logic [ADDR_W-1:0] fetch_addr,
  output logic fetch_valid,
  output logic line_start,
  output logic frame_start,
  output logic rotated,
  output logic split_active
);
  import prs_pkg::*;
  // ********************************************************
  // apb slave
  // ********************************************************
  logic [7:0] clk_cfg_q;
  logic [7:0] horiz_blank_len_q;
  logic [7:0] vert_blank_len_q;
  logic [7:0] sa_low_q;
  logic [7:0] sa_mid_q;
  logic [7:0] sa_high_q;
  logic [7:0] rot_q;
  logic [7:0] stride_q;
  logic [7:0] split_q;
  wire logic [7:0] idx = paddr[PRS_ADDR_LSB +: 8];
  wire logic aligned = paddr[PRS_ADDR_LSB-1:0] == '0 && paddr[11:PRS_ADDR_LSB+8] == '0;
  wire logic acc = psel && penable;
  wire logic wr = acc && pwrite && aligned;
  wire logic hit_clk = idx == PRS_IDX_CLOCK_CONFIG;
  wire logic hit_h = idx == PRS_IDX_HORIZ_NDP;
  wire logic hit_v = idx == PRS_IDX_VERT_NDP;
  wire logic hit_sl = idx == PRS_IDX_START_LOW;
  wire logic hit_sm = idx == PRS_IDX_START_MID;
  wire logic hit_sh = idx == PRS_IDX_START_HIGH;
  wire logic hit_rot = idx == PRS_IDX_ROTATION;
  wire logic hit_str = idx == PRS_IDX_LINE_STRIDE;
  wire logic hit_spl = idx == PRS_IDX_SPLIT_CTRL;
  wire logic hit_st = idx == PRS_IDX_STATUS;
  wire logic mapped = aligned && (hit_clk || hit_h || hit_v || hit_sl || hit_sm || hit_sh
    || hit_rot || hit_str || hit_spl || hit_st);
  // ********************************************************
  // mode decode
  // ********************************************************
  wire logic rot_en = rot_q[PRS_ROT_EN_BIT];
  wire logic alt_sel = rot_q[PRS_ROT_ALT_BIT];
  wire logic mclk_eq = rot_q[PRS_ROT_MCLK_BIT];
  wire logic [1:0] psel_bits = rot_q[PRS_ROT_PSEL_HI:0];
  wire prs_mode_t mode = prs_mode_t'(!rot_en ? PRS_LANDSCAPE :
    (alt_sel ? PRS_ROT_ALT : PRS_ROT_DEFAULT));
  wire logic split_ok = split_q[PRS_SPLIT_EN_BIT] && !rot_en;
  wire logic [7:0] status = {4'h0, split_ok, mode == PRS_ROT_ALT, mode == PRS_ROT_DEFAULT,
    rot_en};
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_clk) rd_mux[7:0] = clk_cfg_q;
    if (hit_h) rd_mux[7:0] = horiz_blank_len_q;
    if (hit_v) rd_mux[7:0] = vert_blank_len_q;
    if (hit_sl) rd_mux[7:0] = sa_low_q;
    if (hit_sm) rd_mux[7:0] = sa_mid_q;
    if (hit_sh) rd_mux[7:0] = sa_high_q;
    if (hit_rot) rd_mux[7:0] = rot_q;
    if (hit_str) rd_mux[7:0] = stride_q;
    if (hit_spl) rd_mux[7:0] = split_q;
    if (hit_st) rd_mux[7:0] = status;
  end
  // ********************************************************
  // register file
  // ********************************************************
  // a write lands only at the access edge, where pready is already high
  wire logic wr_ok = wr && pready;
  wire logic [7:0] wbyte = pwdata[7:0];
  wire logic we_clk = wr_ok && hit_clk;
  wire logic we_h = wr_ok && hit_h;
  wire logic we_v = wr_ok && hit_v;
  wire logic we_sl = wr_ok && hit_sl;
  wire logic we_sm = wr_ok && hit_sm;
  wire logic we_sh = wr_ok && hit_sh;
  wire logic we_rot = wr_ok && hit_rot;
  wire logic we_str = wr_ok && hit_str;
  wire logic we_spl = wr_ok && hit_spl;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_cfg_q <= PRS_CLK_CFG_RESET;
    end else if (we_clk) begin
      clk_cfg_q <= wbyte;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      horiz_blank_len_q <= PRS_RESET_BYTE;
    end else if (we_h) begin
      horiz_blank_len_q <= wbyte;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vert_blank_len_q <= PRS_RESET_BYTE;
    end else if (we_v) begin
      vert_blank_len_q <= wbyte;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sa_low_q <= PRS_RESET_BYTE;
    end else if (we_sl) begin
      sa_low_q <= wbyte;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sa_mid_q <= PRS_RESET_BYTE;
    end else if (we_sm) begin
      sa_mid_q <= wbyte;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sa_high_q <= PRS_RESET_BYTE;
    end else if (we_sh) begin
      sa_high_q <= wbyte;
    end
  end
  // reserved rotation bits are masked so they read back zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rot_q <= PRS_RESET_BYTE;
    end else if (we_rot) begin
      rot_q <= wbyte & PRS_ROT_WMASK;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stride_q <= PRS_RESET_BYTE;
    end else if (we_str) begin
      stride_q <= wbyte;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      split_q <= PRS_RESET_BYTE;
    end else if (we_spl) begin
      split_q <= wbyte;
    end
  end
  // ********************************************************
  // bus response
  // ********************************************************
  // single-cycle answer: pready high in every access phase
  // read data stays until the next read setup
  wire logic setup = psel && !penable;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= setup && !mapped;
      if (setup && !pwrite) prdata <= mapped ? rd_mux : 32'h0000_0000;
    end
  end
  // ********************************************************
  // clock enables
  // ********************************************************
  // input clock is pclk itself; slower rates are enables
  // widest divide is alternate at select three, so the counter must hold sixteen
  function automatic logic [PRS_CNT_W-1:0] pix_div(input prs_mode_t m, input logic [1:0] s);
    logic [PRS_CNT_W-1:0] base;
    base = (m == PRS_ROT_ALT) ? PRS_CNT_W'(PRS_ALT_PIX_DIV)
      : PRS_CNT_W'(PRS_DEF_PIX_DIV);
    if (m == PRS_LANDSCAPE) return PRS_CNT_W'(PRS_DEF_PIX_DIV);
    return base << s;
  endfunction
  wire logic [PRS_CNT_W-1:0] pdiv = pix_div(mode, psel_bits);
  // memory runs at input rate in alt scheme, or with rotation on at bit 2 or during host access
  wire logic mclk_fast = mode == PRS_ROT_ALT || (rot_en && mclk_eq)
    || (rot_en && host_access);
  wire logic [PRS_CNT_W-1:0] mdiv = mclk_fast ? PRS_CNT_W'(1) : PRS_CNT_W'(PRS_MCLK_SLOW_DIV);
  wire logic ptick;
  wire logic mtick;
  prs_div #(.W(PRS_CNT_W)) u_pix (
    .clk(pclk),
    .rst_n(presetn),
    .run(1'b1),
    .div(pdiv),
    .tick(ptick)
  );
  prs_div #(.W(PRS_CNT_W)) u_mem (
    .clk(pclk),
    .rst_n(presetn),
    .run(1'b1),
    .div(mdiv),
    .tick(mtick)
  );
  // ********************************************************
  // scan address generator
  // ********************************************************
  // memory is never touched here, so contents stay as written
  wire logic [ADDR_W-1:0] start_raw = ADDR_W'({sa_high_q[0], sa_mid_q, sa_low_q});
  // default scheme drops the lowest line-step bit of the pan, giving two-line steps
  wire logic [ADDR_W-1:0] stride = ADDR_W'(stride_q);
  function automatic logic [ADDR_W-1:0] pan_start(input prs_mode_t m,
    input logic [ADDR_W-1:0] sa, input logic [ADDR_W-1:0] st);
    logic [ADDR_W-1:0] lines;
    lines = (st == '0) ? '0 : sa / st;
    case (m)
      PRS_ROT_DEFAULT: return sa - ((lines % ADDR_W'(PRS_DEF_PAN_LINES)) * st);
      PRS_ROT_ALT: return sa;
      default: return ADDR_W'({sa[ADDR_W-2:0], 1'b0}); // word offset in landscape
    endcase
  endfunction
  wire logic [ADDR_W-1:0] base = pan_start(mode, start_raw, stride);
  logic [ADDR_W-1:0] line_q;
  logic [ADDR_W-1:0] addr_q;
  logic [9:0] col_q;
  logic [9:0] row_q;
  prs_scan_t st_q;
  wire logic [9:0] h_total = horiz_active_len + 10'(horiz_blank_len_q);
  wire logic [9:0] v_total = vert_active_len + 10'(vert_blank_len_q);
  wire logic col_end = col_q + 10'd1 >= h_total;
  wire logic row_end = row_q + 10'd1 >= v_total;
  wire logic in_view = col_q < horiz_active_len && row_q < vert_active_len;
  // rotated refresh walks down the byte columns: start points at the top-right byte
  wire logic [ADDR_W-1:0] step = rot_en ? stride : ADDR_W'(1);
  // ********************************************************
  // scan state
  // ********************************************************
  wire logic scan_idle = st_q == PRS_IDLE;
  wire logic scan_pix = st_q == PRS_PIXEL;
  wire logic scan_line = st_q == PRS_LINE;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= PRS_IDLE;
    end else if (ptick) begin
      case (st_q)
        PRS_IDLE: begin
          st_q <= PRS_PIXEL;
        end
        PRS_PIXEL: begin
          if (col_end) st_q <= PRS_LINE;
        end
        PRS_LINE: begin
          st_q <= PRS_PIXEL;
        end
        default: begin
          st_q <= PRS_IDLE;
        end
      endcase
    end
  end
  // ********************************************************
  // scan counters
  // ********************************************************
  // a frame restarts from base, so a start-address write shows at the next frame
  wire logic col_we = ptick && (scan_idle || scan_pix);
  wire logic row_we = ptick && (scan_idle || scan_line);
  wire logic addr_we = ptick && (scan_idle || scan_line || (scan_pix && in_view));
  wire logic [9:0] col_d = (scan_idle || col_end) ? 10'd0 : col_q + 10'd1;
  wire logic [9:0] row_d = (scan_idle || row_end) ? 10'd0 : row_q + 10'd1;
  wire logic [ADDR_W-1:0] line_next = rot_en ? line_q - ADDR_W'(1) : addr_q;
  wire logic [ADDR_W-1:0] line_d = (scan_idle || row_end) ? base : line_next;
  wire logic [ADDR_W-1:0] addr_d = scan_pix ? addr_q + step : line_d;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      col_q <= '0;
      row_q <= '0;
    end else begin
      if (col_we) col_q <= col_d;
      if (row_we) row_q <= row_d;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_q <= '0;
      addr_q <= '0;
    end else begin
      if (row_we) line_q <= line_d;
      if (addr_we) addr_q <= addr_d;
    end
  end
  // ********************************************************
  // outputs
  // ********************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pixel_tick <= 1'b0;
      mem_tick <= 1'b0;
      fetch_addr <= '0;
      fetch_valid <= 1'b0;
      line_start <= 1'b0;
      frame_start <= 1'b0;
      rotated <= 1'b0;
      split_active <= 1'b0;
    end else begin
      pixel_tick <= ptick;
      mem_tick <= mtick;
      fetch_addr <= addr_q;
      fetch_valid <= ptick && st_q == PRS_PIXEL && in_view;
      line_start <= ptick && st_q == PRS_LINE;
      frame_start <= ptick && st_q == PRS_LINE && row_end;
      rotated <= rot_en;
      split_active <= split_ok;
    end
  end
endmodule

// ### prs_pkg.sv
package prs_pkg;
  // ********************************************************
  // register map (indices; byte address is index times four)
  // ********************************************************
  localparam logic [7:0] PRS_IDX_CLOCK_CONFIG = 8'h02;
  localparam logic [7:0] PRS_IDX_HORIZ_NDP = 8'h08;
  localparam logic [7:0] PRS_IDX_VERT_NDP = 8'h0A;
  localparam logic [7:0] PRS_IDX_START_LOW = 8'h0C;
  localparam logic [7:0] PRS_IDX_START_MID = 8'h0D;
  localparam logic [7:0] PRS_IDX_START_HIGH = 8'h0E;
  localparam logic [7:0] PRS_IDX_ROTATION = 8'h1B;
  localparam logic [7:0] PRS_IDX_LINE_STRIDE = 8'h1C;
  localparam logic [7:0] PRS_IDX_SPLIT_CTRL = 8'h20;
  localparam logic [7:0] PRS_IDX_STATUS = 8'h21;
  localparam int PRS_ADDR_LSB = 2;
  // ********************************************************
  // field positions
  // ********************************************************
  localparam int PRS_ROT_EN_BIT = 7;
  localparam int PRS_ROT_ALT_BIT = 6;
  localparam int PRS_ROT_MCLK_BIT = 2;
  localparam int PRS_ROT_PSEL_HI = 1;
  localparam int PRS_CLK_DIV_BIT = 4;
  localparam int PRS_SPLIT_EN_BIT = 0;
  localparam logic [7:0] PRS_ROT_WMASK = 8'hC7;
  localparam logic [7:0] PRS_RESET_BYTE = 8'h00;
  localparam logic [7:0] PRS_CLK_CFG_RESET = 8'h00;
  // ********************************************************
  // clock and geometry figures
  // ********************************************************
  localparam int PRS_PCLK_HZ = 40000000;
  localparam int PRS_ALT_PIX_DIV = 2;
  localparam int PRS_DEF_PIX_DIV = 1;
  localparam int PRS_DEF_PAN_LINES = 2;
  localparam int PRS_ALT_PAN_LINES = 1;
  localparam int PRS_ADDR_W = 17;
  localparam int PRS_CNT_W = 5;
  localparam int PRS_MCLK_SLOW_DIV = 2;
  typedef enum logic [1:0] {PRS_LANDSCAPE, PRS_ROT_DEFAULT, PRS_ROT_ALT} prs_mode_t;
  typedef enum logic [1:0] {PRS_IDLE, PRS_LINE, PRS_PIXEL} prs_scan_t;
endpackage

// ### prs_div.sv
`timescale 1ns/10ps
// ********************************************************
// enable divider: one-cycle pulse every div cycles
// ********************************************************
module prs_div #(
  parameter int W = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [W-1:0] div,
  output logic tick
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  wire logic last = (cnt_q + W'(1)) >= div;
  assign cnt_d = (!run || last) ? '0 : cnt_q + W'(1);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      tick <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick <= run && last;
    end
  end
endmodule

// ### prs_scan_props.sv
`timescale 1ns/10ps
// ********************************************************
// port checker, rotation shadowed from apb writes
// ********************************************************
module prs_scan_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic host_access,
  input wire logic pixel_tick,
  input wire logic mem_tick,
  input wire logic rotated,
  input wire logic split_active
);
  import prs_pkg::*;
  logic [7:0] rot_q;
  logic [3:0] age_q;
  wire rot_hit = paddr == {2'b00, PRS_IDX_ROTATION, 2'b00};
  wire wr_rot = psel && penable && pready && pwrite && rot_hit;
  // mode checks wait until the dividers have had time to follow a write
  wire settled = age_q == 4'hF;
  wire rot_def = settled && rot_q[7] && !rot_q[6];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rot_q <= 8'h00;
      age_q <= 4'h0;
    end else begin
      rot_q <= wr_rot ? (pwdata[7:0] & PRS_ROT_WMASK) : rot_q;
      age_q <= wr_rot ? 4'h0 : (settled ? age_q : age_q + 4'h1);
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence half_tick;
    !pixel_tick ##1 pixel_tick;
  endsequence
  split_off_a: assert property (rotated |-> !split_active)
    else $error("split active while rotated");
  rot_level_a: assert property (settled |-> rotated == rot_q[7])
    else $error("rotated flag differs from enable");
  def_rate_a: assert property (rot_def && rot_q[1:0] == 2'b00 |-> pixel_tick)
    else $error("default pixel rate not input rate");
  alt_rate_a: assert property (settled && rot_q[7:6] == 2'b11 && rot_q[1:0] == 2'b00
    && pixel_tick |=> half_tick) else $error("alternate pixel rate not half");
  div_sel_a: assert property (rot_def && rot_q[1:0] == 2'b01 && pixel_tick
    |=> half_tick) else $error("pixel select not dividing");
  alt_mem_a: assert property (settled && rot_q[7:6] == 2'b11 |-> mem_tick)
    else $error("alternate memory rate low");
  fast_mem_a: assert property (settled && rot_q[7] && rot_q[2] |-> mem_tick)
    else $error("memory clock not input clock");
  host_mem_a: assert property ((settled && rot_q[7] && host_access)[*3] |-> mem_tick)
    else $error("memory not sped up on host access");
  ready_next_a: assert property (psel && !penable |=> pready)
    else $error("no ready in access cycle");
  bad_addr_a: assert property (pready && paddr == 12'h3FC |-> pslverr
    && (pwrite || prdata == 32'h0))
    else $error("unmapped address not refused");
endmodule
bind prs_scan prs_scan_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .host_access(host_access), .pixel_tick(pixel_tick),
  .mem_tick(mem_tick), .rotated(rotated), .split_active(split_active));

// ### prs_panel_model.sv
`timescale 1ns/10ps
// ********************************************************
// panel sink: counts frames seen on the refresh side
// ********************************************************
module prs_panel_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic frame_start,
  output int frames
);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frames <= 0;
    end else if (frame_start === 1'b1) begin
      frames <= frames + 1;
    end
  end
endmodule

// ### prs_scan_tb.sv
`timescale 1ns/10ps
// ********************************************************
// scan block bench
// ********************************************************
module prs_scan_tb;
  import prs_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, host_access = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd, pc, mc;
  logic [9:0] horiz_active_len = 10'h004, vert_active_len = 10'h004;
  logic pready, pslverr, pixel_tick, mem_tick, fetch_valid, line_start, frame_start;
  logic rotated, split_active, err;
  logic [16:0] fetch_addr, fa0, fa1;
  int fails = 0, check_count = 0, frames;
  initial forever #12.5 pclk = ~pclk;
  prs_scan u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .host_access(host_access), .horiz_active_len(horiz_active_len),
    .vert_active_len(vert_active_len), .pixel_tick(pixel_tick), .mem_tick(mem_tick),
    .fetch_addr(fetch_addr), .fetch_valid(fetch_valid), .line_start(line_start),
    .frame_start(frame_start), .rotated(rotated), .split_active(split_active));
  prs_panel_model u_panel (.pclk(pclk), .presetn(presetn), .frame_start(frame_start),
    .frames(frames));
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    for (i = 0; i < 16 && pready !== 1'b1; i++) @(posedge pclk);
    if (i == 16) begin
      fails++;
      end_sim();
    end
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic limit(input int i);
    if (i >= 400) begin
      fails++;
      end_sim();
    end
  endtask
  // first two fetches of a fresh frame; the extra edge skips a stale pulse
  task automatic fetch2;
    int i;
    repeat (2) @(posedge pclk);
    for (i = 0; i < 400 && frame_start !== 1'b1; i++) @(posedge pclk);
    limit(i);
    for (i = 0; i < 400 && fetch_valid !== 1'b1; i++) @(posedge pclk);
    limit(i);
    fa0 = fetch_addr;
    @(posedge pclk);
    for (i = 0; i < 400 && fetch_valid !== 1'b1; i++) @(posedge pclk);
    limit(i);
    fa1 = fetch_addr;
  endtask
  // counts both tick outputs over eight cycles once the mode has settled
  task automatic ticks;
    repeat (20) @(posedge pclk);
    pc = 0;
    mc = 0;
    repeat (8) begin
      @(posedge pclk);
      pc += pixel_tick;
      mc += mem_tick;
    end
  endtask
  task automatic t_regs;
    logic [7:0] idx [7] = '{PRS_IDX_CLOCK_CONFIG, PRS_IDX_HORIZ_NDP, PRS_IDX_VERT_NDP,
      PRS_IDX_START_LOW, PRS_IDX_START_MID, PRS_IDX_START_HIGH, PRS_IDX_LINE_STRIDE};
    foreach (idx[i]) begin
      apb(0, idx[i], 0);
      check("reset", rd, 0);
      apb(1, idx[i], 32'h5A);
      apb(0, idx[i], 0);
      check("readback", {rd[31:1], err}, 32'h5A);
    end
    apb(1, 8'hFF, 32'h5A);
    check("bad wr err", err, 1);
    apb(0, 8'hFF, 0);
    check("bad rd", {rd[31:1], err}, 1);
  endtask
  task automatic t_default;
    apb(1, PRS_IDX_HORIZ_NDP, 2);
    apb(1, PRS_IDX_VERT_NDP, 2);
    apb(1, PRS_IDX_START_LOW, 32'h7F);
    apb(1, PRS_IDX_START_MID, 0);
    apb(1, PRS_IDX_LINE_STRIDE, 32'h80);
    apb(1, PRS_IDX_ROTATION, 32'h80);
    ticks();
    check("def pix", pc, 8);
    check("def mem", mc, 4);
    check("rotated", rotated, 1);
    repeat (64) @(posedge pclk);
    check("frames", {31'b0, frames > 0}, 1);
    host_access <= 1;
    ticks();
    check("host mem", mc, 8);
    host_access <= 0;
    apb(1, PRS_IDX_ROTATION, 32'h81);
    ticks();
    check("sel pix", pc, 4);
    apb(1, PRS_IDX_ROTATION, 32'h84);
    ticks();
    check("fast mem", mc, 8);
  endtask
  task automatic t_alt;
    apb(1, PRS_IDX_CLOCK_CONFIG, 0);
    apb(1, PRS_IDX_LINE_STRIDE, 32'h78);
    apb(1, PRS_IDX_ROTATION, 32'hC0);
    ticks();
    check("alt pix", pc, 4);
    check("alt mem", mc, 8);
    apb(0, PRS_IDX_ROTATION, 0);
    check("alt mode", rd, 32'hC0);
    apb(0, PRS_IDX_STATUS, 0);
    check("status", rd, 32'h05);
    apb(1, PRS_IDX_ROTATION, 32'hFF);
    apb(0, PRS_IDX_ROTATION, 0);
    check("rot mask", rd, 32'hC7);
  endtask
  task automatic t_scan;
    apb(1, PRS_IDX_ROTATION, 0);
    apb(1, PRS_IDX_START_LOW, 32'h10);
    apb(1, PRS_IDX_START_MID, 0);
    fetch2();
    check("land base", fa0, 32'h20);
    check("land step", fa1 - fa0, 32'h1);
    apb(1, PRS_IDX_LINE_STRIDE, 32'h80);
    apb(1, PRS_IDX_START_LOW, 32'h7F);
    apb(1, PRS_IDX_ROTATION, 32'h80);
    fetch2();
    check("def base", fa0, 32'h7F);
    check("def step", fa1 - fa0, 32'h80);
    apb(1, PRS_IDX_START_LOW, 32'hFF);
    fetch2();
    check("def pan", fa0, 32'h7F);
    apb(1, PRS_IDX_LINE_STRIDE, 32'h78);
    apb(1, PRS_IDX_START_LOW, 32'hEF);
    apb(1, PRS_IDX_ROTATION, 32'hC0);
    fetch2();
    check("alt pan", fa0, 32'hEF);
    check("alt step", fa1 - fa0, 32'h78);
  endtask
  task automatic t_split;
    apb(1, PRS_IDX_ROTATION, 0);
    apb(1, PRS_IDX_SPLIT_CTRL, 1);
    ticks();
    check("land split", split_active, 1);
    check("land rot", rotated, 0);
    apb(1, PRS_IDX_ROTATION, 32'h80);
    ticks();
    check("rot split", split_active, 0);
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    t_regs();
    t_default();
    t_alt();
    t_scan();
    t_split();
    end_sim();
  end
endmodule
